// ---- src/tmr_defines.vh ----
`ifndef TMR_DEFINES_VH
`define TMR_DEFINES_VH

// ==========================================
// Register byte addresses (one aligned word each)
`define ADDR_TIMER_CTRL 12'h000
`define ADDR_COUNTER 12'h004
`define ADDR_MODULO 12'h008
`define ADDR_CH_BASE 12'h010
`define CH_STRIDE 12'h010
`define OFS_SC 12'h000
`define OFS_VH 12'h004
`define OFS_VL 12'h008

// ==========================================
// Field positions, timer control
`define TC_CLKSEL_LO 0
`define TC_CLKSEL_HI 1
`define TC_PRESCALE_LO 2
`define TC_PRESCALE_HI 4
`define TC_CENTER 5

// ==========================================
// Field positions, channel status/control
`define SC_ELS_LO 2
`define SC_ELS_HI 3
`define SC_MSA 4
`define SC_MSB 5
`define SC_FLAG 7

// ==========================================
// Reset values and constants
`define RST_TIMER_CTRL 8'h00
`define RST_MODULO 16'h0000
`define RST_SC 8'h00
`define CLKSEL_OFF 2'h0
`define CNT_FREE_TOP 16'hffff
`define CNT_FREE_PRE 16'hfffe
`define NUM_CH 2

`endif

// ---- src/tmr_prescaler.v ----
`timescale 1ns/1ps
// ==========================================
// Prescaler: tick every 2^div enabled clocks
module tmr_prescaler (
    input wire clk_i,
    input wire rst_i,
    input wire run_i,
    input wire [2:0] div_i,
    output wire tick_o
);
    reg [6:0] cnt_q;
    wire [6:0] top;

    assign top = (7'h01 << div_i) - 7'h01;
    assign tick_o = run_i && (cnt_q >= top);

    always @(posedge clk_i) begin
        if (rst_i || !run_i || tick_o) begin
            cnt_q <= 7'h00;
        end else begin
            cnt_q <= cnt_q + 7'h01;
        end
    end
endmodule // tmr_prescaler

// ---- src/tmr_channel.v ----
// The register addresses and the APB interface to the registers are this design's own decisions.
`timescale 1ns/1ps
`include "tmr_defines.vh"
// ==========================================
// One channel: status/control, coherent value path, flag, pin
module tmr_channel (
    input wire clk_i,
    input wire rst_i,
    input wire debug_active_mode_i,
    input wire center_aligned_select_i,
    input wire clk_off_i,
    input wire cnt_tick_i,
    input wire [15:0] counter_i,
    input wire [15:0] counter_modulo_i,
    input wire free_run_i,
    input wire wr_sc_i,
    input wire wr_vh_i,
    input wire wr_vl_i,
    input wire rd_sc_i,
    input wire rd_vh_i,
    input wire rd_vl_i,
    input wire [7:0] wdata_i,
    input wire pin_i,
    output wire [7:0] chan_status_ctrl_o,
    output wire [7:0] chan_value_high_o,
    output wire [7:0] chan_value_low_o,
    output reg pin_o,
    output wire pin_oe_o,
    output wire chan_event_flag_o
);
    reg [7:0] sc_q;
    reg [15:0] value_q;
    reg [7:0] buf_hi_q;
    reg [7:0] buf_lo_q;
    reg got_hi_q;
    reg got_lo_q;
    reg pend_q;
    reg [7:0] rd_lo_q;
    reg rd_latched_q;
    reg flag_armed_q;
    reg pin_d1_q;
    wire [1:0] els;
    wire input_capture;
    wire edge_aligned_pwm;
    wire center_aligned_pwm;
    wire output_compare;
    wire pair_done;
    wire apply_now;
    wire apply_evt;
    wire match;
    wire duty_edge;
    wire cap_edge;
    wire set_flag;
    wire pwm_on;

    assign els = sc_q[`SC_ELS_HI:`SC_ELS_LO];
    assign center_aligned_pwm = center_aligned_select_i;
    assign edge_aligned_pwm = !center_aligned_select_i && sc_q[`SC_MSB];
    assign input_capture = !center_aligned_select_i && !sc_q[`SC_MSB] && !sc_q[`SC_MSA];
    assign output_compare = !center_aligned_select_i && !sc_q[`SC_MSB] && sc_q[`SC_MSA];

    // Second byte completes the pair (either order)
    assign pair_done = !debug_active_mode_i && !input_capture &&
        ((wr_vh_i && got_lo_q) || (wr_vl_i && got_hi_q)); // RQ10
    assign apply_now = pair_done && clk_off_i; // RQ6
    assign apply_evt = pend_q && !clk_off_i && cnt_tick_i &&
        (output_compare || // RQ7
         (free_run_i ? (counter_i == `CNT_FREE_PRE) // RQ9
                     : (counter_i == counter_modulo_i - 16'h0001))); // RQ8

    // Channel flag on match, not at 0% or 100% duty
    assign match = (counter_i == value_q) && !input_capture;
    assign duty_edge = (edge_aligned_pwm || center_aligned_pwm) &&
        ((value_q == 16'h0000) || (value_q > counter_modulo_i));
    assign cap_edge = input_capture && (els != 2'h0) &&
        ((els[0] && pin_i && !pin_d1_q) || (els[1] && !pin_i && pin_d1_q));
    assign set_flag = (match && !duty_edge && cnt_tick_i) || cap_edge; // RQ17
    assign pwm_on = counter_i < value_q;

    always @(posedge clk_i) begin
        if (rst_i) begin
            sc_q <= `RST_SC;
            value_q <= 16'h0000;
            buf_hi_q <= 8'h00;
            buf_lo_q <= 8'h00;
            got_hi_q <= 1'b0;
            got_lo_q <= 1'b0;
            pend_q <= 1'b0;
            rd_lo_q <= 8'h00;
            rd_latched_q <= 1'b0;
            flag_armed_q <= 1'b0;
            pin_d1_q <= 1'b0;
            pin_o <= 1'b0;
        end else begin
            pin_d1_q <= pin_i;
            flag_armed_q <= rd_sc_i ? sc_q[`SC_FLAG] : (flag_armed_q && !set_flag);
            if (wr_sc_i) begin
                sc_q[6:0] <= wdata_i[6:0];
                // Clear only after read while set; new event wins
                if (set_flag) begin
                    sc_q[`SC_FLAG] <= 1'b1;
                end else if (flag_armed_q && !wdata_i[`SC_FLAG]) begin
                    sc_q[`SC_FLAG] <= 1'b0;
                end
                got_hi_q <= 1'b0; // RQ1
                got_lo_q <= 1'b0; // RQ1
                rd_latched_q <= 1'b0; // RQ1
            end else begin
                if (set_flag) begin
                    sc_q[`SC_FLAG] <= 1'b1;
                end
                if (debug_active_mode_i) begin
                    if (!input_capture && wr_vh_i) begin
                        value_q[15:8] <= wdata_i; // RQ11
                    end
                    if (!input_capture && wr_vl_i) begin
                        value_q[7:0] <= wdata_i; // RQ11
                    end
                end else if (!input_capture) begin // RQ2
                    if (wr_vh_i) begin
                        buf_hi_q <= wdata_i; // RQ5
                    end
                    if (wr_vl_i) begin
                        buf_lo_q <= wdata_i; // RQ5
                    end
                    if (pair_done) begin
                        got_hi_q <= 1'b0;
                        got_lo_q <= 1'b0;
                    end else begin
                        got_hi_q <= got_hi_q || wr_vh_i;
                        got_lo_q <= got_lo_q || wr_vl_i;
                    end
                end
                // Read coherency: high byte read freezes low byte
                if (!debug_active_mode_i) begin // RQ3
                    if (rd_vh_i) begin
                        rd_lo_q <= value_q[7:0];
                        rd_latched_q <= 1'b1;
                    end else if (rd_vl_i) begin
                        rd_latched_q <= 1'b0;
                    end
                end
            end
            if (apply_now) begin
                value_q <= wr_vh_i ? {wdata_i, buf_lo_q} : {buf_hi_q, wdata_i}; // RQ5
            end else if (apply_evt) begin
                value_q <= {buf_hi_q, buf_lo_q}; // RQ12
                pend_q <= 1'b0;
            end
            if (pair_done && !clk_off_i) begin
                pend_q <= 1'b1;
            end
            if (edge_aligned_pwm || center_aligned_pwm) begin
                pin_o <= els[1] ? pwm_on : !pwm_on;
            end else if (output_compare && match && cnt_tick_i) begin
                pin_o <= (els == 2'h1) ? !pin_o : els[0];
            end
        end
    end

    assign pin_oe_o = (els != 2'h0) && !input_capture; // RQ16
    assign chan_status_ctrl_o = sc_q;
    assign chan_value_high_o = value_q[15:8];
    assign chan_value_low_o = (rd_latched_q && !debug_active_mode_i) ?
        rd_lo_q : value_q[7:0]; // RQ4
    assign chan_event_flag_o = sc_q[`SC_FLAG];
endmodule // tmr_channel

// ---- src/tmr_top.v ----
`timescale 1ns/1ps
`include "tmr_defines.vh"
// Contract
// RQ1 - Control write clears partial value latches
// RQ2 - Input capture ignores value writes
// RQ3 - Debug freezes read coherency latches
// RQ4 - Debug reads return live value
// RQ5 - Buffer bytes, load pair coherently
// RQ6 - Clock off: load on second byte
// RQ7 - Compare mode: load on next tick
// RQ8 - PWM: load at modulo minus one step
// RQ9 - Free-running PWM: load at 0xfffe step
// RQ10 - Accept bytes in either order
// RQ11 - Debug writes go straight to register
// RQ12 - Debug writes keep pending pair intact
// RQ13 - Shared 16-bit counter and modulo
// RQ14 - Global center-aligned select overrides channels
// RQ15 - Center-aligned counts up and down
// RQ16 - Edge/level 0:0 releases pin
// RQ17 - Flag on match, not 0%/100%
// RQ18 - Debug-active input selects debug behaviour
module tmr_top (
    input wire clk_i,
    input wire rst_i,
    input wire psel_i,
    input wire penable_i,
    input wire pwrite_i,
    input wire [11:0] paddr_i,
    input wire [31:0] pwdata_i,
    output wire [31:0] prdata_o,
    output wire pready_o,
    output wire pslverr_o,
    input wire debug_active_mode_i,
    input wire [1:0] pin_i,
    output wire [1:0] pin_o,
    output wire [1:0] pin_oe_o,
    output wire [1:0] chan_event_flag_o
);
    reg [7:0] ctrl_q;
    reg [15:0] counter_modulo_q;
    reg [15:0] counter_q;
    reg down_q;
    reg [31:0] rdata_q;
    reg err_q;
    wire access;
    wire [1:0] counter_clock_select;
    wire clk_off;
    wire tick;
    wire free_run;
    wire [15:0] top;
    wire ch_hit [0:1];
    wire [11:0] ch_ofs [0:1];
    wire [7:0] ch_sc [0:1];
    wire [7:0] ch_vh [0:1];
    wire [7:0] ch_vl [0:1];
    reg [31:0] rd_d;
    reg err_d;

    // ==========================================
    // APB slave, zero wait states
    assign access = psel_i && penable_i;
    assign pready_o = 1'b1;
    assign pslverr_o = err_q;
    assign prdata_o = rdata_q;

    assign counter_clock_select = ctrl_q[`TC_CLKSEL_HI:`TC_CLKSEL_LO];
    assign clk_off = counter_clock_select == `CLKSEL_OFF;
    assign free_run = counter_modulo_q == 16'h0000;
    assign top = free_run ? `CNT_FREE_TOP : counter_modulo_q;

    tmr_prescaler tmr_prescaler_inst (
        .clk_i(clk_i),
        .rst_i(rst_i),
        .run_i(!clk_off),
        .div_i(ctrl_q[`TC_PRESCALE_HI:`TC_PRESCALE_LO]),
        .tick_o(tick)
    );

    // ==========================================
    // Shared counter
    always @(posedge clk_i) begin
        if (rst_i) begin
            ctrl_q <= `RST_TIMER_CTRL;
            counter_modulo_q <= `RST_MODULO;
            counter_q <= 16'h0000;
            down_q <= 1'b0;
        end else begin
            if (access && pwrite_i && paddr_i == `ADDR_TIMER_CTRL) begin
                ctrl_q <= pwdata_i[7:0];
            end
            if (access && pwrite_i && paddr_i == `ADDR_MODULO) begin
                counter_modulo_q <= pwdata_i[15:0];
            end
            if (access && pwrite_i && paddr_i == `ADDR_COUNTER) begin
                counter_q <= 16'h0000;
                down_q <= 1'b0;
            end else if (tick) begin // RQ13
                if (ctrl_q[`TC_CENTER]) begin // RQ15
                    if (!down_q && counter_q >= top) begin
                        down_q <= 1'b1;
                        counter_q <= counter_q - 16'h0001;
                    end else if (down_q && counter_q <= 16'h0001) begin
                        down_q <= 1'b0;
                        counter_q <= 16'h0000;
                    end else begin
                        counter_q <= down_q ? counter_q - 16'h0001 : counter_q + 16'h0001;
                    end
                end else begin
                    down_q <= 1'b0;
                    counter_q <= (counter_q >= top) ? 16'h0000 : counter_q + 16'h0001;
                end
            end
        end
    end

    // ==========================================
    // Channels
    genvar g;
    generate
        for (g = 0; g < `NUM_CH; g = g + 1) begin : g_ch
            localparam [31:0] BASE_W = `ADDR_CH_BASE + g * `CH_STRIDE;
            wire [11:0] base;
            assign base = BASE_W[11:0];
            assign ch_ofs[g] = paddr_i - base;
            assign ch_hit[g] = paddr_i >= base && paddr_i < base + `CH_STRIDE;
            tmr_channel tmr_channel_inst (
                .clk_i(clk_i),
                .rst_i(rst_i),
                .debug_active_mode_i(debug_active_mode_i), // RQ18
                .center_aligned_select_i(ctrl_q[`TC_CENTER]), // RQ14
                .clk_off_i(clk_off),
                .cnt_tick_i(tick),
                .counter_i(counter_q),
                .counter_modulo_i(top),
                .free_run_i(free_run),
                .wr_sc_i(access && pwrite_i && ch_hit[g] && ch_ofs[g] == `OFS_SC),
                .wr_vh_i(access && pwrite_i && ch_hit[g] && ch_ofs[g] == `OFS_VH),
                .wr_vl_i(access && pwrite_i && ch_hit[g] && ch_ofs[g] == `OFS_VL),
                .rd_sc_i(access && !pwrite_i && ch_hit[g] && ch_ofs[g] == `OFS_SC),
                .rd_vh_i(access && !pwrite_i && ch_hit[g] && ch_ofs[g] == `OFS_VH),
                .rd_vl_i(access && !pwrite_i && ch_hit[g] && ch_ofs[g] == `OFS_VL),
                .wdata_i(pwdata_i[7:0]),
                .pin_i(pin_i[g]),
                .chan_status_ctrl_o(ch_sc[g]),
                .chan_value_high_o(ch_vh[g]),
                .chan_value_low_o(ch_vl[g]),
                .pin_o(pin_o[g]),
                .pin_oe_o(pin_oe_o[g]),
                .chan_event_flag_o(chan_event_flag_o[g])
            );
        end
    endgenerate

    // ==========================================
    // Read mux, registered in setup phase
    always @* begin
        rd_d = 32'h00000000;
        err_d = 1'b0;
        if (paddr_i == `ADDR_TIMER_CTRL) begin
            rd_d = {24'h000000, ctrl_q};
        end else if (paddr_i == `ADDR_COUNTER) begin
            rd_d = {16'h0000, counter_q};
        end else if (paddr_i == `ADDR_MODULO) begin
            rd_d = {16'h0000, counter_modulo_q};
        end else if (ch_hit[0] || ch_hit[1]) begin
            if (ch_ofs[ch_hit[1]] == `OFS_SC) begin
                rd_d = {24'h000000, ch_sc[ch_hit[1]]};
            end else if (ch_ofs[ch_hit[1]] == `OFS_VH) begin
                rd_d = {24'h000000, ch_vh[ch_hit[1]]};
            end else if (ch_ofs[ch_hit[1]] == `OFS_VL) begin
                rd_d = {24'h000000, ch_vl[ch_hit[1]]};
            end else begin
                err_d = 1'b1;
            end
        end else begin
            err_d = 1'b1;
        end
    end

    always @(posedge clk_i) begin
        if (rst_i) begin
            rdata_q <= 32'h00000000;
            err_q <= 1'b0;
        end else if (psel_i && !penable_i) begin
            rdata_q <= pwrite_i ? 32'h00000000 : rd_d;
            err_q <= err_d;
        end
    end
endmodule // tmr_top

// ---- dv/tmr_monitor.sv ----
`timescale 1ns/1ps
// ==========================================
// Port checker
module tmr_monitor (
    input wire clk_i,
    input wire rst_i,
    input wire psel_i,
    input wire penable_i,
    input wire pwrite_i,
    input wire [11:0] paddr_i,
    input wire [31:0] pwdata_i,
    input wire [31:0] prdata_o,
    input wire pready_o,
    input wire pslverr_o,
    input wire debug_active_mode_i,
    input wire [1:0] pin_i,
    input wire [1:0] pin_o,
    input wire [1:0] pin_oe_o,
    input wire [1:0] chan_event_flag_o
);
    logic acc, wr, mapped, center_q;
    logic [3:0] sc0_q, sc1_q;
    logic [7:0] dbg_q;
    assign acc = psel_i && penable_i;
    assign wr = acc && pwrite_i;
    assign mapped = paddr_i inside {12'h000, 12'h004, 12'h008, 12'h010, 12'h014, 12'h018,
                                    12'h020, 12'h024, 12'h028};
    function automatic logic drives(input logic [3:0] sc, input logic c);
        return sc[1:0] != 2'h0 && (c || sc[3:2] != 2'h0);
    endfunction
    always @(posedge clk_i) begin
        if (rst_i) begin
            center_q <= 1'b0;
            sc0_q <= 4'h0;
            sc1_q <= 4'h0;
            dbg_q <= 8'h00;
        end else if (wr) begin
            if (paddr_i == 12'h000) center_q <= pwdata_i[5];
            if (paddr_i == 12'h010) sc0_q <= pwdata_i[5:2];
            if (paddr_i == 12'h020) sc1_q <= pwdata_i[5:2];
            dbg_q <= pwdata_i[7:0];
        end
    end
    default clocking cb @(posedge clk_i); endclocking
    default disable iff (rst_i);
    pready_high_a: assert property (acc |-> pready_o) else $error("pready low in access");
    bad_addr_err_a: assert property (acc && !mapped |-> pslverr_o) else $error("no slverr");
    good_addr_ok_a: assert property (acc && mapped |-> !pslverr_o) else $error("false slverr");
    reset_quiet_a: assert property (disable iff (1'b0) rst_i |=> chan_event_flag_o == 2'h0
        && pin_oe_o == 2'h0 && pslverr_o == 1'b0) else $error("outputs not cleared by reset");
    pin_drive0_a: assert property (pin_oe_o[0] == drives(sc0_q, center_q))
        else $error("channel 0 pin enable wrong");
    pin_drive1_a: assert property (pin_oe_o[1] == drives(sc1_q, center_q))
        else $error("channel 1 pin enable wrong");
    debug_live_a: assert property (wr && debug_active_mode_i && paddr_i == 12'h018
        && (center_q || sc0_q[3:2] != 2'h0) ##2 (psel_i && !penable_i && !pwrite_i
        && paddr_i == 12'h018 && debug_active_mode_i) |=> prdata_o[7:0] == dbg_q)
        else $error("debug read not live value");
    flag_keep_a: assert property (chan_event_flag_o[0] && !(wr && paddr_i == 12'h010)
        |=> chan_event_flag_o[0]) else $error("flag dropped without control write");
endmodule // tmr_monitor

bind tmr_top tmr_monitor tmr_monitor_inst (.clk_i(clk_i), .rst_i(rst_i), .psel_i(psel_i),
    .penable_i(penable_i), .pwrite_i(pwrite_i), .paddr_i(paddr_i), .pwdata_i(pwdata_i),
    .prdata_o(prdata_o), .pready_o(pready_o), .pslverr_o(pslverr_o),
    .debug_active_mode_i(debug_active_mode_i), .pin_i(pin_i), .pin_o(pin_o),
    .pin_oe_o(pin_oe_o), .chan_event_flag_o(chan_event_flag_o));

// ---- dv/tmr_apb_host.sv ----
`timescale 1ns/1ps
// ==========================================
// Processor bus master model
module tmr_apb_host (
    input wire clk_i,
    output logic psel_o,
    output logic penable_o,
    output logic pwrite_o,
    output logic [11:0] paddr_o,
    output logic [31:0] pwdata_o,
    input wire [31:0] prdata_i,
    input wire pready_i,
    input wire pslverr_i
);
    initial begin
        psel_o = 1'b0;
        penable_o = 1'b0;
        pwrite_o = 1'b0;
        paddr_o = 12'h000;
        pwdata_o = 32'h00000000;
    end
    task automatic xfer(input logic w, input logic [11:0] a, input logic [31:0] d,
                        output logic [31:0] r, output logic e);
        @(posedge clk_i);
        psel_o <= 1'b1;
        penable_o <= 1'b0;
        pwrite_o <= w;
        paddr_o <= a;
        pwdata_o <= d;
        @(posedge clk_i);
        penable_o <= 1'b1;
        do @(posedge clk_i); while (pready_i !== 1'b1);
        r = prdata_i;
        e = pslverr_i;
        psel_o <= 1'b0;
        penable_o <= 1'b0;
        pwdata_o <= ~d;
    endtask
endmodule // tmr_apb_host

// ---- dv/timer_channel_value_coherency_tb.sv ----
`timescale 1ns/1ps
// ==========================================
// Value path testbench
module timer_channel_value_coherency_tb;
    logic clk_i = 1'b0, rst_i = 1'b1, psel, penable, pwrite, pslverr, pready, dbg = 1'b0;
    logic [11:0] paddr;
    logic [31:0] pwdata, prdata, r;
    logic [1:0] pin_o, pin_oe, flag;
    logic [15:0] expv, v, c0, c1;
    logic e;
    logic [31:0] seed = 32'ha3e12693;
    int failures = 0, num_checks = 0;
    initial forever #25 clk_i = ~clk_i;
    tmr_apb_host tmr_apb_host_inst (.clk_i(clk_i), .psel_o(psel), .penable_o(penable),
        .pwrite_o(pwrite), .paddr_o(paddr), .pwdata_o(pwdata), .prdata_i(prdata),
        .pready_i(pready), .pslverr_i(pslverr));
    tmr_top tmr_top_inst (.clk_i(clk_i), .rst_i(rst_i), .psel_i(psel), .penable_i(penable),
        .pwrite_i(pwrite), .paddr_i(paddr), .pwdata_i(pwdata), .prdata_o(prdata),
        .pready_o(pready), .pslverr_o(pslverr), .debug_active_mode_i(dbg), .pin_i(2'b00),
        .pin_o(pin_o), .pin_oe_o(pin_oe), .chan_event_flag_o(flag));
    function automatic logic [31:0] xs();
        seed = seed ^ (seed << 13);
        seed = seed ^ (seed >> 17);
        seed = seed ^ (seed << 5);
        return seed;
    endfunction
    task automatic chk(input logic [31:0] seen, input logic [31:0] exp);
        num_checks++;
        if (seen !== exp) begin
            failures++;
            $display("CHECK FAILED t=%0t seen=%h exp=%h", $time, seen, exp);
        end
    endtask
    task automatic wr(input logic [11:0] a, input logic [31:0] d);
        tmr_apb_host_inst.xfer(1'b1, a, d, r, e);
    endtask
    task automatic rd(input logic [11:0] a);
        tmr_apb_host_inst.xfer(1'b0, a, 32'h0, r, e);
    endtask
    task automatic rv(input logic [11:0] b, output logic [15:0] o);
        dbg <= 1'b1;
        rd(b + 12'h004);
        o[15:8] = r[7:0];
        rd(b + 12'h008);
        o[7:0] = r[7:0];
        dbg <= 1'b0;
    endtask
    task automatic tick_wait();
        rd(12'h004);
        c0 = r[15:0];
        do begin
            rd(12'h004);
        end while (r[15:0] == c0);
    endtask
    task automatic wrap_wait();
        c0 = 16'h0000;
        do begin
            c1 = c0;
            rd(12'h004);
            c0 = r[15:0];
        end while (c0 >= c1);
    endtask
    task automatic test_done();
        $display("checks=%0d failures=%0d", num_checks, failures);
        if (failures == 0 && num_checks > 0) $display("*** PASS ***");
        else $display("*** FAIL ***");
        $finish;
    endtask
    initial begin
        repeat (90000) @(posedge clk_i);
        failures++;
        test_done();
    end
    initial begin
        repeat (16) @(posedge clk_i);
        rst_i <= 1'b0;
        foreach (c1[i]) begin
            rd(12'h000 + 12'(i[1:0]) * 12'h008);
            chk(r, 32'h0);
        end
        rd(12'h0fc);
        chk({31'h0, e}, 32'h1);
        wr(12'h000, 32'h00);
        wr(12'h010, 32'h14);
        expv = 16'h0000;
        for (int i = 0; i < 6; i++) begin
            v = xs();
            wr(v[0] ? 12'h014 : 12'h018, v[0] ? v[15:8] : v[7:0]);
            rv(12'h010, c1);
            chk(c1, expv);
            wr(v[0] ? 12'h018 : 12'h014, v[0] ? v[7:0] : v[15:8]);
            expv = v;
            rv(12'h010, c1);
            chk(c1, expv);
        end
        wr(12'h014, 32'haa);
        wr(12'h010, 32'h14);
        wr(12'h018, 32'h55);
        rv(12'h010, c1);
        chk(c1, expv);
        wr(12'h014, 32'h66);
        rv(12'h010, c1);
        chk(c1, 16'h6655);
        rd(12'h014);
        dbg <= 1'b1;
        wr(12'h018, 32'h77);
        rd(12'h018);
        chk(r[7:0], 8'h77);
        dbg <= 1'b0;
        rd(12'h018);
        chk(r[7:0], 8'h55);
        wr(12'h014, 32'h12);
        dbg <= 1'b1;
        wr(12'h014, 32'h9a);
        wr(12'h018, 32'hbc);
        rv(12'h010, c1);
        chk(c1, 16'h9abc);
        wr(12'h018, 32'h34);
        rv(12'h010, c1);
        chk(c1, 16'h1234);
        wr(12'h010, 32'h04);
        v = xs();
        wr(12'h014, v[15:8]);
        wr(12'h018, v[7:0]);
        dbg <= 1'b1;
        wr(12'h014, v[7:0]);
        rv(12'h010, c1);
        chk(c1, 16'h1234);
        wr(12'h000, 32'h1d);
        wr(12'h010, 32'h14);
        tick_wait();
        v = xs();
        wr(12'h014, v[15:8]);
        wr(12'h018, v[7:0]);
        rv(12'h010, c1);
        chk(c1, 16'h1234);
        tick_wait();
        rv(12'h010, c1);
        chk(c1, v);
        expv = v;
        wr(12'h000, 32'h01);
        wr(12'h008, 32'h80);
        wr(12'h010, 32'h28);
        do rd(12'h004); while (r[15:0] >= 16'h0020);
        v = 16'h0030 + 16'(xs() & 32'h3f);
        wr(12'h018, v[7:0]);
        wr(12'h014, v[15:8]);
        rv(12'h010, c1);
        chk(c1, expv);
        wrap_wait();
        rv(12'h010, c1);
        chk(c1, v);
        rd(12'h010);
        wr(12'h010, 32'h28);
        for (int i = 0; i < 200 && flag[0] !== 1'b1; i++) @(posedge clk_i);
        chk(flag[0], 1'b1);
        chk({pin_oe[0], pin_o[0]}, 2'b10);
        wr(12'h018, 32'h00);
        wr(12'h014, 32'h00);
        wrap_wait();
        rd(12'h010);
        wr(12'h010, 32'h28);
        repeat (300) @(posedge clk_i);
        chk(flag[0], 1'b0);
        wr(12'h000, 32'h21);
        wr(12'h004, 32'h00);
        wrap_wait();
        chk(c0[15:4], 12'h007);
        wr(12'h000, 32'h01);
        wr(12'h008, 32'h00);
        wr(12'h010, 32'h28);
        wr(12'h004, 32'h00);
        v = xs() | 32'h1;
        wr(12'h014, v[15:8]);
        wr(12'h018, v[7:0]);
        rv(12'h010, c1);
        chk(c1, 16'h0000);
        repeat (65540) @(posedge clk_i);
        rv(12'h010, c1);
        chk(c1, v);
        test_done();
    end
endmodule // timer_channel_value_coherency_tb
